// ### sim/sob_enc_model.sv
/*
 * Shaft encoder with once-per-turn index pair.
 * Assumes the drive's speed output tells it whether the shaft turns.
 */
`timescale 1ns/1ps
`default_nettype none
module sob_enc_model #(
    parameter int HALF = 4,
    parameter int PPR = 128
) (
    // Clock and motion enable
    input wire logic hclk,
    input wire logic spin,
    // Encoder lines
    output logic enc_a,
    output logic enc_b,
    output logic idx_p,
    output logic idx_n
);
    int ph = 0; // Phase within one pulse
    int cnt = 0; // Pulse within one turn
    // Shaft stands still when no speed is asked for
    always @(posedge hclk) begin
        if (spin) begin
            ph <= (ph + 1) % (2 * HALF);
            if (ph == 2 * HALF - 1) begin
                cnt <= (cnt + 1) % PPR;
            end
        end
    end
    assign enc_a = ph < HALF;
    assign enc_b = ph >= HALF / 2 && ph < HALF + HALF / 2;
    // Index at pulse zero marks division zero
    assign idx_p = cnt == 0 && enc_a;
    assign idx_n = !idx_p;
endmodule
`default_nettype wire

// ### sim/sob_top_asserts.sv
/*
 * Port checker for the orientation and bias block.
 * Assumes it is bound to every sob_top instance.
 */
`timescale 1ns/1ps
`default_nettype none
module sob_top_asserts (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Watched ports
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic run_cmd,
    input wire logic orient_request_input,
    input wire logic position_ready_output,
    input wire logic servo_lock,
    input wire logic position_cmd_valid,
    input wire logic decel_time_bypass
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Zero wait states, always OKAY
    AST_NO_WAIT: assert property (hreadyout)
        else $error("hreadyout low");
    AST_OKAY: assert property (!hresp)
        else $error("hresp not okay");
    AST_READY_CLEAR: assert property (!orient_request_input |-> ##2 !position_ready_output)
        else $error("ready outlived orient");
    AST_READY_HOLD: assert property ($fell(position_ready_output) |->
        !$past(orient_request_input) || !$past(orient_request_input, 2))
        else $error("ready fell with orient high");
    AST_LOCK_RUN: assert property (!run_cmd |-> ##2 !servo_lock)
        else $error("lock outlived run");
    AST_VALID_PULSE: assert property (position_cmd_valid |=> !position_cmd_valid)
        else $error("valid longer than one cycle");
    AST_BYPASS_READY: assert property (decel_time_bypass |-> !position_ready_output)
        else $error("ready during approach");
    AST_READY_CAUSE: assert property ($rose(position_ready_output) |->
        $past(run_cmd) && $past(orient_request_input))
        else $error("ready without run and orient");
    // Main scenarios reached
    COV_READY: cover property ($rose(position_ready_output));
    COV_LOCK: cover property ($rose(servo_lock));
    COV_BYPASS: cover property ($rose(decel_time_bypass));
endmodule
bind sob_top sob_top_asserts chk_u (.hclk, .hresetn, .hreadyout, .hresp, .run_cmd,
    .orient_request_input, .position_ready_output, .servo_lock, .position_cmd_valid,
    .decel_time_bypass);
`default_nettype wire

// ### sim/tb_top.sv
/*
 * Self-checking bench: registers, bias and orientation.
 * Assumes a shortened bias period of 50 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sob_map.svh"
module tb_top;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
    logic [1:0] htrans = 2'h0;
    logic run = 1'h0, orient = 1'h0, badd = 1'h0, sreach = 1'h0, pstep = 1'h0;
    logic signed [15:0] scmd = 16'h0;
    wire logic hready, hresp, ea, eb, ip, in, pv, rdy, lock, byp;
    wire logic [31:0] hrdata;
    wire logic signed [15:0] sref, pdel;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    // Write flag, offset, data, expected read
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} sob_row_t;
    sob_row_t rows [11] = '{
        '{1'h0, `SOB_OFF_CTRL, 32'h0, 32'h0},
        '{1'h0, `SOB_OFF_ENC, 32'h0, 32'h400},
        '{1'h0, `SOB_OFF_GEAR, 32'h0, 32'h10001},
        '{1'h0, `SOB_OFF_OSPD, 32'h0, 32'h1F4},
        '{1'h0, `SOB_OFF_READY, 32'h0, 32'h5},
        '{1'h0, 8'h30, 32'h0, 32'h0},
        '{1'h1, `SOB_OFF_ENC, 32'h10, 32'h80},
        '{1'h1, `SOB_OFF_GEAR, 32'h07D02710, 32'h07D0270F},
        '{1'h1, `SOB_OFF_GEAR, 32'h10001, 32'h10001},
        '{1'h1, `SOB_OFF_OSPD, 32'h3000, 32'h2EE0},
        '{1'h1, 8'h30, 32'hFF, 32'h0}};
    sob_top #(.BIAS_PERIOD_CYC(50)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata,
        .enc_a(ea), .enc_b(eb), .index_pulse_positive(ip), .index_pulse_negative(in),
        .run_cmd(run), .orient_request_input(orient), .bias_add_input(badd),
        .speed_reached(sreach), .speed_cmd_in(scmd), .pulse_step(pstep),
        .pulse_dir(1'h0), .speed_ref_out(sref), .position_cmd_delta(pdel),
        .position_cmd_valid(pv), .position_ready_output(rdy), .servo_lock(lock),
        .decel_time_bypass(byp));
    // Shaft turns whenever a speed is asked for
    sob_enc_model enc_u (.hclk, .spin(sref != 0), .enc_a(ea), .enc_b(eb), .idx_p(ip),
        .idx_n(in));
    initial begin
        forever #5 hclk = ~hclk;
    end
    task automatic wrap_up;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // One single transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'h1);
        q = hrdata;
    endtask
    // Step off the present pulse, then wait for the next bias tick
    task automatic nextv;
        @(negedge hclk);
        for (int k = 0; k < 200 && pv !== 1'h1; k++) @(negedge hclk);
    endtask
    // Hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        foreach (rows[i]) begin
            if (rows[i].w) xfer(1'h1, rows[i].a, rows[i].d);
            xfer(1'h0, rows[i].a, 32'h0);
            chk($sformatf("reg %h", rows[i].a), rows[i].e, q);
        end
        // Position bias, negative then cancelled by three pulses
        xfer(1'h1, `SOB_OFF_CTRL, 32'h1);
        xfer(1'h1, `SOB_OFF_PBIAS, 32'hFFFFFFFD);
        nextv();
        nextv();
        chk("delta", 32'hFFFD, {16'h0, pdel});
        repeat (3) begin
            @(posedge hclk);
            pstep <= 1'h1;
            @(posedge hclk);
            pstep <= 1'h0;
        end
        nextv();
        chk("delta", 32'h0, {16'h0, pdel});
        // Speed bias added, then subtracted
        xfer(1'h1, `SOB_OFF_FBIAS, 32'h64);
        scmd <= 16'hC8;
        badd <= 1'h1;
        repeat (4) @(negedge hclk);
        chk("speed", 32'h12C, {16'h0, sref});
        xfer(1'h1, `SOB_OFF_CTRL, 32'h5);
        repeat (4) @(negedge hclk);
        chk("speed", 32'h64, {16'h0, sref});
        // Orientation to division zero at a low orient speed
        xfer(1'h1, `SOB_OFF_OSPD, 32'h1F4);
        @(posedge hclk);
        badd <= 1'h0;
        orient <= 1'h1;
        run <= 1'h1;
        sreach <= 1'h1;
        repeat (3) @(negedge hclk);
        chk("orient speed", 32'h1F4, {16'h0, sref});
        for (int k = 0; k < 6000 && rdy !== 1'h1; k++) @(negedge hclk);
        chk("ready", 32'h1, {31'h0, rdy});
        xfer(1'h0, `SOB_OFF_STATUS, 32'h0);
        chk("status", 32'h1D, q & 32'h1F);
        // Run drops first: lock ends, ready stays
        @(posedge hclk);
        run <= 1'h0;
        scmd <= 16'h0;
        repeat (3) @(negedge hclk);
        chk("lock", 32'h0, {31'h0, lock});
        chk("ready", 32'h1, {31'h0, rdy});
        @(posedge hclk);
        orient <= 1'h0;
        repeat (3) @(negedge hclk);
        chk("ready", 32'h0, {31'h0, rdy});
        // Reset after run and orient have dropped, with the shaft at rest
        @(posedge hclk);
        hresetn <= 1'h0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        xfer(1'h0, `SOB_OFF_ENC, 32'h0);
        chk("enc", 32'h400, q);
        xfer(1'h0, `SOB_OFF_MPOS, 32'h0);
        chk("mpos", 32'h0, q);
        wrap_up();
    end
endmodule
`default_nettype wire

// ### src/sob_map.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * spindle orientation and bias block.
 * Assumes inclusion by bare name from every file that needs a figure.
 */
`ifndef SOB_MAP_SVH
`define SOB_MAP_SVH

// Register byte offsets, one aligned word each
`define SOB_OFF_CTRL 8'h00
`define SOB_OFF_ENC 8'h04
`define SOB_OFF_GEAR 8'h08
`define SOB_OFF_STOP 8'h0C
`define SOB_OFF_OSPD 8'h10
`define SOB_OFF_READY 8'h14
`define SOB_OFF_GAIN 8'h18
`define SOB_OFF_PBIAS 8'h1C
`define SOB_OFF_FBIAS 8'h20
`define SOB_OFF_STATUS 8'h24
`define SOB_OFF_MSPEED 8'h28
`define SOB_OFF_MPOS 8'h2C

// Control register bits
`define SOB_CTRL_PT_MODE 0
`define SOB_CTRL_ODIR 1
`define SOB_CTRL_FBSIGN 2

// Field positions of packed registers
`define SOB_GEAR_DEN_LSB 16
`define SOB_READY_DLY_LSB 16
`define SOB_STAT_READY 3
`define SOB_STAT_LOCK 4
`define SOB_STAT_REM_LSB 16

// Reset values and setting limits
`define SOB_ENC_RST 16'h0400
`define SOB_ENC_MIN 16'h0080
`define SOB_GEAR_RST 16'h0001
`define SOB_GEAR_MAX 16'h270F
`define SOB_STOP_RST 12'h000
`define SOB_OSPD_RST 16'h01F4
`define SOB_OSPD_MAX 16'h2EE0
`define SOB_RANGE_RST 16'h0005
`define SOB_RANGE_MAX 16'h270F
`define SOB_DELAY_RST 10'h000
`define SOB_DELAY_MAX 10'h3E7
`define SOB_GAIN_RST 16'h0032
`define SOB_GAIN_MAX 16'h2710
`define SOB_PBIAS_MAX 16'h0800
`define SOB_PBIAS_MIN 16'hF800

// Stop position resolution and loop scaling
`define SOB_DIV_BITS 12
`define SOB_GAIN_SHIFT 8

// Timing: bias period and the 0.01 s delay unit in bias periods
`define SOB_CLK_MHZ 100
`define SOB_BIAS_PERIOD_US 2000
`define SOB_BIAS_PERIOD_CYC (`SOB_BIAS_PERIOD_US * `SOB_CLK_MHZ)
`define SOB_DELAY_TICKS 3'h5
// Cycles after reset before encoder steps count
`define SOB_WARM_CYC 3'h7

`endif

// ### src/sob_pkg.sv
/*
 * Types shared by the spindle orientation and bias block.
 * Assumes sob_map.svh is on the include path.
 */
package sob_pkg;

    // Orientation sequence states
    typedef enum logic [2:0] {
        SOB_IDLE, SOB_ACCEL, SOB_SEEK, SOB_POSN, SOB_SETTLE, SOB_LOCK
    } sob_state_t;

    // Software settings travel together
    typedef struct packed {
        logic pt_mode;
        logic odir;
        logic fbsign;
        logic [15:0] enc;
        logic [15:0] gnum;
        logic [15:0] gden;
        logic [11:0] stop;
        logic [15:0] ospd;
        logic [15:0] range;
        logic [9:0] delay;
        logic [15:0] gain;
        logic signed [15:0] pbias;
        logic [15:0] fbias;
    } sob_cfg_t;

    // Clamp an unsigned setting into its legal span
    function automatic logic [15:0] sob_clamp(input logic [15:0] v,
                                              input logic [15:0] lo,
                                              input logic [15:0] hi);
        sob_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

endpackage

// ### src/sob_sync.sv
/*
 * Three-stage pin synchroniser; a change is taken once stages two
 * and three agree. Assumes pins are asynchronous to hclk.
 */
`timescale 1ns/1ps
`default_nettype none

module sob_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Raw pins and filtered result
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    logic [W-1:0] s1; // Only read by s2
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // Shift chain; output follows only on agreement
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            level <= '0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            level <= (s2 == s3) ? s3 : level;
        end
    end

endmodule

`default_nettype wire

// ### src/sob_tick.sv
/*
 * Free-running divider giving a one-cycle enable pulse every PERIOD
 * clocks. Assumes PERIOD is at least 2.
 */
`timescale 1ns/1ps
`default_nettype none

module sob_tick #(
    parameter int PERIOD = 200000
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Enable pulse
    output logic tick
);
    logic [31:0] cnt; // Cycles since last pulse
    wire logic wrap = (cnt == 32'(PERIOD - 1));

    // Count and pulse on wrap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= '0;
            tick <= 1'b0;
        end else begin
            cnt <= wrap ? '0 : cnt + 32'h1;
            tick <= wrap;
        end
    end

endmodule

`default_nettype wire

// ### src/sob_top.sv
/*
 * Spindle orientation and bias: gear-scaled encoder feedback, position
 * and speed bias in pulse-train mode, and index-referenced orientation
 * with a position-ready output. Registers sit behind an AHB-Lite slave.
 * Assumes encoder and index pins are asynchronous; run, orient, bias
 * and pulse inputs come from logic on hclk.
 */
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sob_map.svh"

module sob_top
    import sob_pkg::*;
#(
    parameter int BIAS_PERIOD_CYC = `SOB_BIAS_PERIOD_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Encoder pins
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic index_pulse_positive,
    input wire logic index_pulse_negative,
    // Drive-side controls
    input wire logic run_cmd,
    input wire logic orient_request_input,
    input wire logic bias_add_input,
    input wire logic speed_reached,
    input wire logic signed [15:0] speed_cmd_in,
    input wire logic pulse_step,
    input wire logic pulse_dir,
    // Drive-side results
    output logic signed [15:0] speed_ref_out,
    output logic signed [15:0] position_cmd_delta,
    output logic position_cmd_valid,
    output logic position_ready_output,
    output logic servo_lock,
    output logic decel_time_bypass
);

    // x1 quadrature step: count on A rising, B high means reverse
    function automatic logic signed [1:0] sob_enc_step(input logic a_old,
                                                       input logic a_new,
                                                       input logic b);
        sob_enc_step = (!a_old && a_new) ? (b ? 2'sb11 : 2'sb01) : 2'sb00;
    endfunction

    sob_cfg_t cfg; // Software settings
    sob_state_t state; // Orientation sequence
    sob_state_t next_state;

    // Bus address phase capture
    logic wr_pend;
    logic [7:0] wr_addr;
    wire logic take = hsel && hready && htrans[1];
    wire logic [7:0] addr_lo = {haddr[7:2], 2'b00};

    // Synchronised pins
    logic [3:0] pins;
    logic a_prev; // Last filtered A level
    logic idx_prev; // Last index state
    wire logic a_now = pins[0];
    wire logic b_now = pins[1];
    // Index is seen when the pair is driven positive
    wire logic idx_now = pins[2] && !pins[3];
    wire logic idx_rise = idx_now && !idx_prev;
    logic [2:0] warm; // Steps wait until the synchroniser shows real pin levels
    wire logic signed [1:0] step = (warm == `SOB_WARM_CYC) ? sob_enc_step(a_prev, a_now, b_now)
                                                              : 2'sb00;

    // Gear scaling: residue carries fractional motor pulses
    logic signed [23:0] residue;
    logic signed [31:0] motor_pos;
    logic signed [15:0] win_steps; // Motor steps in this bias period
    logic signed [15:0] motor_speed; // Steps per bias period
    wire logic signed [23:0] num_s = {8'h00, cfg.gnum};
    wire logic signed [23:0] den_s = {8'h00, cfg.gden};
    wire logic signed [23:0] res_in = (step == 2'sb01) ? residue + num_s :
                                     (step == 2'sb11) ? residue - num_s : residue;
    wire logic gear_up = (res_in >= den_s);
    wire logic gear_dn = (res_in <= -den_s);
    wire logic signed [1:0] mstep = gear_up ? 2'sb01 : (gear_dn ? 2'sb11 : 2'sb00);

    // Bias period tick
    logic tick;
    logic signed [15:0] pt_accum; // Pulse-train change in this period

    // Orientation geometry in raw encoder pulses
    wire logic [27:0] stop_prod = 28'(cfg.stop) * 28'(cfg.enc);
    wire logic [15:0] stop_pulses = stop_prod[27:`SOB_DIV_BITS];
    wire logic signed [19:0] target = 20'(stop_pulses) +
                                      (cfg.odir ? 20'(cfg.enc) << 1 : 20'(cfg.enc));
    logic signed [19:0] dir_pos; // Pulses since index, in run direction
    wire logic signed [19:0] remaining = target - dir_pos;
    wire logic [19:0] rem_abs = remaining[19] ? -remaining : remaining;
    wire logic in_range = (rem_abs <= 20'(cfg.range));

    // Loop speed: gain times error, never above orient speed
    wire logic [35:0] loop_prod = 36'(cfg.gain) * 36'(rem_abs);
    wire logic [35:0] loop_shift = loop_prod >> `SOB_GAIN_SHIFT;
    wire logic [15:0] loop_mag = (loop_shift > 36'(cfg.ospd)) ? cfg.ospd : loop_shift[15:0];
    wire logic loop_fwd = cfg.odir ? remaining[19] : !remaining[19];
    wire logic signed [15:0] loop_spd = loop_fwd ? loop_mag : -loop_mag;
    wire logic signed [15:0] orient_spd = cfg.odir ? -cfg.ospd : cfg.ospd;

    // Speed bias with its own sign bit
    wire logic signed [15:0] fbias_s = cfg.fbsign ? -cfg.fbias : cfg.fbias;
    wire logic bias_on = cfg.pt_mode && bias_add_input;
    wire logic signed [15:0] base_spd = bias_on ? speed_cmd_in + fbias_s : speed_cmd_in;

    // Settle delay counted in bias periods
    logic [12:0] dly_cnt;
    wire logic dly_done = (dly_cnt == 13'h0000);

    // Synchronise encoder and index pins
    sob_sync #(.W(4)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin({index_pulse_negative, index_pulse_positive, enc_b, enc_a}),
        .level(pins)
    );

    // Bias period divider
    sob_tick #(.PERIOD(BIAS_PERIOD_CYC)) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick)
    );

    // Next orientation state; orient drop always aborts
    always_comb begin
        next_state = state;
        case (state)
            SOB_IDLE: begin
                // Covers run-then-orient and orient-then-run alike
                if (orient_request_input && run_cmd) next_state = SOB_ACCEL;
            end
            SOB_ACCEL: begin
                if (speed_reached) next_state = SOB_SEEK;
            end
            SOB_SEEK: begin
                if (idx_rise) next_state = SOB_POSN;
            end
            SOB_POSN: begin
                if (in_range) next_state = SOB_SETTLE;
            end
            SOB_SETTLE: begin
                if (dly_done) next_state = SOB_LOCK;
            end
            SOB_LOCK: begin
                next_state = SOB_LOCK;
            end
            default: next_state = SOB_IDLE;
        endcase
        // Lock and ready stay until their own inputs drop
        if (!orient_request_input) next_state = SOB_IDLE;
        else if (!run_cmd && state != SOB_LOCK) next_state = SOB_IDLE;
    end

    // Sequence register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) state <= SOB_IDLE;
        else state <= next_state;
    end

    // Position since index; cleared on the index so division zero sits there
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_pos <= '0;
        end else if (state == SOB_SEEK && idx_rise) begin
            dir_pos <= '0;
        end else if (step != 2'sb00) begin
            // Count along the orient direction
            dir_pos <= (cfg.odir ? dir_pos - 20'(step) : dir_pos + 20'(step));
        end
    end

    // Settle delay: load on entry, count bias periods
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dly_cnt <= '0;
        end else if (state == SOB_POSN) begin
            dly_cnt <= 13'(cfg.delay) * 13'(`SOB_DELAY_TICKS);
        end else if (state == SOB_SETTLE && tick && !dly_done) begin
            dly_cnt <= dly_cnt - 13'h0001;
        end
    end

    // Orientation outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            position_ready_output <= 1'b0;
            servo_lock <= 1'b0;
            decel_time_bypass <= 1'b0;
        end else begin
            position_ready_output <= (next_state == SOB_LOCK);
            servo_lock <= (next_state == SOB_LOCK) && run_cmd;
            decel_time_bypass <= (next_state == SOB_POSN) || (next_state == SOB_SETTLE);
        end
    end

    // Speed reference: orient speed, loop speed, or biased command
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            speed_ref_out <= '0;
        end else begin
            case (state)
                SOB_ACCEL, SOB_SEEK: speed_ref_out <= orient_spd;
                SOB_POSN, SOB_SETTLE, SOB_LOCK: speed_ref_out <= loop_spd;
                default: speed_ref_out <= base_spd;
            endcase
        end
    end

    // Encoder edge tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_prev <= 1'b0;
            idx_prev <= 1'b0;
            warm <= 3'h0;
        end else begin
            a_prev <= a_now;
            idx_prev <= idx_now;
            // A reset-zero level followed by a high pin would look like an edge
            if (warm != `SOB_WARM_CYC) warm <= warm + 3'h1;
        end
    end

    // Gear scaling: one motor step per clock at most, which keeps up with the
    // synchroniser's rate limit on encoder edges only while gnum is at most four times gden
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            residue <= '0;
            motor_pos <= '0;
        end else begin
            residue <= gear_up ? res_in - den_s : (gear_dn ? res_in + den_s : res_in);
            motor_pos <= motor_pos + 32'(mstep);
        end
    end

    // Motor speed as scaled steps per bias period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_steps <= '0;
            motor_speed <= '0;
        end else if (tick) begin
            motor_speed <= win_steps + 16'(mstep);
            win_steps <= '0;
        end else begin
            win_steps <= win_steps + 16'(mstep);
        end
    end

    // Pulse-train change with position bias once per period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pt_accum <= '0;
            position_cmd_delta <= '0;
            position_cmd_valid <= 1'b0;
        end else begin
            position_cmd_valid <= tick && cfg.pt_mode;
            if (tick) begin
                // Signed add: positive bias moves forward
                position_cmd_delta <= pt_accum + cfg.pbias;
                pt_accum <= '0;
            end else if (pulse_step) begin
                pt_accum <= pulse_dir ? pt_accum - 16'sh0001 : pt_accum + 16'sh0001;
            end
        end
    end

    // Bus address phase capture; zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_pend <= take && hwrite;
            wr_addr <= addr_lo;
        end
    end

    // Register writes; out-of-range values are clamped to the legal span, except stop, which keeps only its low 12 bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg.pt_mode <= 1'b0;
            cfg.odir <= 1'b0;
            cfg.fbsign <= 1'b0;
            cfg.enc <= `SOB_ENC_RST;
            cfg.gnum <= `SOB_GEAR_RST;
            cfg.gden <= `SOB_GEAR_RST;
            cfg.stop <= `SOB_STOP_RST;
            cfg.ospd <= `SOB_OSPD_RST;
            cfg.range <= `SOB_RANGE_RST;
            cfg.delay <= `SOB_DELAY_RST;
            cfg.gain <= `SOB_GAIN_RST;
            cfg.pbias <= '0;
            cfg.fbias <= '0;
        end else if (wr_pend) begin
            case (wr_addr)
                `SOB_OFF_CTRL: begin
                    cfg.pt_mode <= hwdata[`SOB_CTRL_PT_MODE];
                    cfg.odir <= hwdata[`SOB_CTRL_ODIR];
                    cfg.fbsign <= hwdata[`SOB_CTRL_FBSIGN];
                end
                `SOB_OFF_ENC: cfg.enc <= sob_clamp(hwdata[15:0], `SOB_ENC_MIN, 16'hFFFF);
                `SOB_OFF_GEAR: begin
                    cfg.gnum <= sob_clamp(hwdata[15:0], 16'h0000, `SOB_GEAR_MAX);
                    // Zero denominator would never divide; hold it at one
                    cfg.gden <= sob_clamp(hwdata[31:`SOB_GEAR_DEN_LSB], `SOB_GEAR_RST,
                                          `SOB_GEAR_MAX);
                end
                `SOB_OFF_STOP: cfg.stop <= hwdata[`SOB_DIV_BITS-1:0];
                `SOB_OFF_OSPD: cfg.ospd <= sob_clamp(hwdata[15:0], 16'h0000, `SOB_OSPD_MAX);
                `SOB_OFF_READY: begin
                    cfg.range <= sob_clamp(hwdata[15:0], 16'h0000, `SOB_RANGE_MAX);
                    cfg.delay <= (hwdata[25:16] > `SOB_DELAY_MAX) ? `SOB_DELAY_MAX
                                                                  : hwdata[25:16];
                end
                `SOB_OFF_GAIN: cfg.gain <= sob_clamp(hwdata[15:0], 16'h0000, `SOB_GAIN_MAX);
                `SOB_OFF_PBIAS: begin
                    // Signed clamp to -2048..2048
                    if ($signed(hwdata[15:0]) > $signed(`SOB_PBIAS_MAX))
                        cfg.pbias <= `SOB_PBIAS_MAX;
                    else if ($signed(hwdata[15:0]) < $signed(`SOB_PBIAS_MIN))
                        cfg.pbias <= `SOB_PBIAS_MIN;
                    else
                        cfg.pbias <= hwdata[15:0];
                end
                `SOB_OFF_FBIAS: cfg.fbias <= sob_clamp(hwdata[15:0], 16'h0000, `SOB_OSPD_MAX);
                default: begin
                    // Unmapped or read-only: write ignored
                end
            endcase
        end
    end

    // Read mux, selected in the address phase
    logic [31:0] rd_next;
    always_comb begin
        case (addr_lo)
            `SOB_OFF_CTRL: rd_next = 32'({cfg.fbsign, cfg.odir, cfg.pt_mode});
            `SOB_OFF_ENC: rd_next = 32'(cfg.enc);
            `SOB_OFF_GEAR: rd_next = {cfg.gden, cfg.gnum};
            `SOB_OFF_STOP: rd_next = 32'(cfg.stop);
            `SOB_OFF_OSPD: rd_next = 32'(cfg.ospd);
            `SOB_OFF_READY: rd_next = {6'h00, cfg.delay, cfg.range};
            `SOB_OFF_GAIN: rd_next = 32'(cfg.gain);
            `SOB_OFF_PBIAS: rd_next = 32'(cfg.pbias);
            `SOB_OFF_FBIAS: rd_next = 32'(cfg.fbias);
            `SOB_OFF_STATUS: rd_next = {remaining[15:0], 11'h000, servo_lock,
                                        position_ready_output, state};
            `SOB_OFF_MSPEED: rd_next = 32'(motor_speed);
            `SOB_OFF_MPOS: rd_next = motor_pos;
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // Read data register; always ready, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hrdata <= '0;
        else if (take && !hwrite) hrdata <= rd_next;
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

endmodule

`default_nettype wire
